// *** rtl/flash_sp_core.sv ***
`timescale 1ns/1ps
// Purpose: processor-side end issuing self-programming commands
// Assumes: software port: address, data, write and read strobes
// Notes: polls enable and eeprom before each command
module flash_sp_core
  import flash_sp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  // software port
  input wire logic [1:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [15:0] rdData,
  output logic cmdPending,
  // eeprom status
  input wire logic eepromWriteBusy,
  // fetch request
  input wire logic [12:0] fetchAddr,
  input wire logic fetchReq,
  // link
  flash_sp_if.core bus
);
  logic [7:0] cmdVal;
  logic [15:0] ptr;
  logic [15:0] data;
  logic [1:0] phase;
  logic ctrlWr;
  logic store;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ptr <= 16'h0000;
      data <= 16'h0000;
    end else if (clkEn && wrStrobe) begin
      if (addr == ADR_PTR) ptr <= wrData;
      if (addr == ADR_DATA) data <= wrData;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmdVal <= 8'h00;
      cmdPending <= 1'b0;
      phase <= 2'h0;
      ctrlWr <= 1'b0;
      store <= 1'b0;
    end else if (clkEn) begin
      ctrlWr <= 1'b0;
      store <= 1'b0;
      if (wrStrobe && addr == ADR_CMD && !cmdPending) begin
        cmdVal <= wrData[7:0];
        cmdPending <= 1'b1;
        phase <= 2'h0;
      end else if (cmdPending) begin
        unique case (phase)
          2'h0: if (!bus.ctrlStatus[SPE_BIT] && !eepromWriteBusy) begin
            ctrlWr <= 1'b1; // [R13] [R14]
            phase <= 2'h1;
          end
          2'h1: begin
            store <= (cmdVal != CMD_REEN); // [R16]
            phase <= 2'h2;
          end
          default: begin
            cmdPending <= 1'b0;
            phase <= 2'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) rdData <= 16'h0000;
    else if (clkEn && rdStrobe) begin
      unique case (addr)
        ADR_CMD: rdData <= {7'h00, cmdPending, bus.ctrlStatus};
        ADR_PTR: rdData <= ptr;
        ADR_DATA: rdData <= data;
        default: rdData <= {15'h0000, bus.fetchOk};
      endcase
    end
  end

  assign bus.ctrlWrData = cmdVal;
  assign bus.ctrlWr = ctrlWr;
  assign bus.store = store;
  // word bits forced to zero for page write, bit 0 for stores
  assign bus.pointer = (cmdVal == CMD_WRITE) ?
    {ptr[15:7], 7'h00} : {ptr[15:1], 1'b0}; // [R8] [R10]
  assign bus.storeData = data;
  assign bus.eepromWriteBusy = eepromWriteBusy;
  assign bus.fetchAddr = fetchAddr;
  assign bus.fetchReq = fetchReq;
endmodule // flash_sp_core

// *** rtl/flash_sp_ctrl.sv ***
`timescale 1ns/1ps
// Purpose: flash self-programming controller, device end
// Assumes: calibrated tick derived by divider of sys_clk
// Notes: page buffer and array are held here as memories
module flash_sp_ctrl
  import flash_sp_pkg::*;
#(
  parameter int WRITE_TIME_TICKS = WRITE_TICKS,
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  // fuses
  input wire logic bootSizeSelHi,
  input wire logic bootSizeSelLo,
  // core link
  flash_sp_if.device bus,
  // flash array read port
  input wire logic [12:0] readAddr,
  output logic [15:0] readData,
  // boot section info
  output logic [12:0] bootStart,
  output logic [10:0] bootWords,
  output logic [7:0] lockBits
);
  initial begin
    if (WRITE_TIME_TICKS < 1 || TICK_DIV < 1)
      $error("flash_sp_ctrl: counts must be positive");
  end

  typedef enum logic [1:0] {
    IDLE = 2'b00, ARMED = 2'b01, BUSY = 2'b11
  } state_t;
  state_t state;
  logic [7:0] cmd;
  logic [2:0] armCount;
  logic [15:0] tickDiv;
  logic tick;
  logic [15:0] timeCount;
  logic sectionBusy;
  logic [15:0] pageBuf [PAGE_WORDS];
  logic [15:0] flashMem [2**PC_WIDTH];
  logic [PAGE_BITS-1:0] opPage;
  logic [PAGE_BITS-1:0] ptrPage;
  logic [WORD_BITS-1:0] ptrWord;
  logic [7:0] lockSrc;

  assign ptrPage = bus.pointer[13:7]; // [R7] [R9]
  assign ptrWord = bus.pointer[6:1]; // [R7] [R6]

  always_comb begin
    unique case ({bootSizeSelHi, bootSizeSelLo}) // [R3] [R4]
      2'b11: begin bootStart = BOOT_START_11; bootWords = BOOT_WORDS_11; end
      2'b10: begin bootStart = BOOT_START_10; bootWords = BOOT_WORDS_10; end
      2'b01: begin bootStart = BOOT_START_01; bootWords = BOOT_WORDS_01; end
      default: begin
        bootStart = BOOT_START_00;
        bootWords = BOOT_WORDS_00;
      end
    endcase
  end

  // calibrated oscillator tick
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tickDiv <= 16'h0000;
    end else if (clkEn) begin
      if (tickDiv == 16'(TICK_DIV - 1)) tickDiv <= 16'h0000; // [R1]
      else tickDiv <= tickDiv + 16'h0001;
    end
  end
  assign tick = clkEn && (tickDiv == 16'(TICK_DIV - 1));

  // command sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= IDLE;
      cmd <= 8'h00;
      armCount <= 3'h0;
      timeCount <= 16'h0000;
      opPage <= '0;
    end else if (clkEn) begin
      unique case (state)
        IDLE: begin
          if (bus.ctrlWr && !bus.eepromWriteBusy &&
              bus.ctrlWrData[SPE_BIT]) begin
            cmd <= {3'b000, bus.ctrlWrData[4:0]};
            armCount <= 3'h0;
            state <= ARMED;
          end
        end
        ARMED: begin
          if (bus.store) begin
            opPage <= ptrPage;
            timeCount <= 16'h0000;
            if (cmd == CMD_ERASE || cmd == CMD_WRITE || cmd == CMD_LOCK)
              state <= BUSY; // [R18]
            else state <= IDLE;
          end else if (armCount == 3'(STORE_WINDOW - 1)) begin
            state <= IDLE; // [R16]
          end else begin
            armCount <= armCount + 3'h1;
          end
        end
        BUSY: begin
          if (tick) begin
            if (timeCount == 16'(WRITE_TIME_TICKS - 1)) state <= IDLE; // [R2]
            else timeCount <= timeCount + 16'h0001;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // page buffer load and array update
  always_ff @(posedge sys_clk) begin
    if (clkEn && state == ARMED && bus.store && cmd == CMD_LOAD)
      pageBuf[ptrWord] <= bus.storeData; // [R15] [R10]
  end
  always_ff @(posedge sys_clk) begin
    if (clkEn && state == BUSY && tick &&
        timeCount == 16'(WRITE_TIME_TICKS - 1)) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        if (cmd == CMD_ERASE)
          flashMem[{opPage, 6'(i)}] <= 16'hFFFF;
        else if (cmd == CMD_WRITE)
          flashMem[{opPage, 6'(i)}] <= pageBuf[i];
      end
    end
  end

  // lock byte, captured from data at the store
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) lockSrc <= 8'hFF;
    else if (clkEn && state == ARMED && bus.store && cmd == CMD_LOCK)
      lockSrc <= bus.storeData[7:0] | 8'hC3;
  end
  assign lockBits = lockSrc;

  // section busy flag
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sectionBusy <= 1'b0;
    end else if (clkEn) begin
      if (state == ARMED && bus.store &&
          (cmd == CMD_ERASE || cmd == CMD_WRITE))
        sectionBusy <= 1'b1; // [R11]
      else if (state == IDLE && bus.ctrlWr && !bus.eepromWriteBusy &&
               bus.ctrlWrData == CMD_REEN)
        sectionBusy <= 1'b0; // [R17] [R12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clkEn) readData <= flashMem[readAddr];
  end

  always_comb begin
    bus.ctrlStatus = 8'h00;
    bus.ctrlStatus[SPE_BIT] = (state != IDLE); // [R18]
    bus.ctrlStatus[4:1] = (state != IDLE) ? cmd[4:1] : 4'h0;
    bus.ctrlStatus[BUSY_BIT] = sectionBusy;
  end
  assign bus.fetchOk = !(sectionBusy && bus.fetchAddr < NON_CONC_START); // [R5] [R12]
endmodule // flash_sp_ctrl

// *** rtl/flash_sp_if.sv ***
`timescale 1ns/1ps
// Purpose: joins processor-side sequencer and flash controller
// Assumes: single clock domain
// Notes: commands are one-cycle strobes
interface flash_sp_if;
  logic [7:0] ctrlWrData;
  logic ctrlWr;
  logic store;
  logic [15:0] pointer;
  logic [15:0] storeData;
  logic eepromWriteBusy;
  logic [7:0] ctrlStatus;
  logic [12:0] fetchAddr;
  logic fetchReq;
  logic fetchOk;
  modport device (
    input ctrlWrData, ctrlWr, store, pointer, storeData, fetchAddr,
    input fetchReq, eepromWriteBusy,
    output ctrlStatus, fetchOk
  );
  modport core (
    output ctrlWrData, ctrlWr, store, pointer, storeData, fetchAddr,
    output fetchReq, eepromWriteBusy,
    input ctrlStatus, fetchOk
  );
endinterface

// *** rtl/flash_sp_pkg.sv ***
// Purpose: constants shared by the flash self-programming ends
// Assumes: one 200 MHz clock; flash timed by a calibrated tick
// Notes: Function
// Function
// (R1) flash writes timed by calibrated oscillator tick
// (R2) erase, write, lock write last 3.7-4.5 ms
// (R3) boot size fuses pick boot start address
// (R4) boot size 128/256/512/1024 words, 2..16 pages
// (R5) words below 0x1C00 concurrent, rest non-concurrent
// (R6) 13-bit pc, 64-word pages, pc[5:0] word
// (R7) page from pointer 13:7, word from 6:1
// (R8) software zeroes word bits for page write
// (R9) pointer bits 15:14 ignored
// (R10) pointer bit 0 byte select, zero for stores
// (R11) concurrent section blocked during erase or write
// (R12) busy flag blocks section until re-enable command
// (R13) software waits for enable clear before command
// (R14) software waits for eeprom idle before command
// (R15) enable-only store loads one buffer word
// (R16) store follows command within four cycles
// (R17) busy flag clears only on re-enable command
// (R18) enable bit held for whole timed write
package flash_sp_pkg;
  localparam int PC_WIDTH = 13;
  localparam int PAGE_WORDS = 64;
  localparam int WORD_BITS = 6;
  localparam int PAGE_BITS = 7;
  localparam logic [12:0] NON_CONC_START = 13'h1C00;
  localparam logic [12:0] BOOT_START_11 = 13'h1F80;
  localparam logic [12:0] BOOT_START_10 = 13'h1F00;
  localparam logic [12:0] BOOT_START_01 = 13'h1E00;
  localparam logic [12:0] BOOT_START_00 = 13'h1C00;
  localparam logic [10:0] BOOT_WORDS_11 = 11'h080;
  localparam logic [10:0] BOOT_WORDS_10 = 11'h100;
  localparam logic [10:0] BOOT_WORDS_01 = 11'h200;
  localparam logic [10:0] BOOT_WORDS_00 = 11'h400;
  // control bits of self_prog_ctrl_status
  localparam int SPE_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCK_BIT = 3;
  localparam int REEN_BIT = 4;
  localparam int BUSY_BIT = 6;
  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] CMD_LOCK = 8'h09;
  localparam logic [7:0] CMD_REEN = 8'h11;
  localparam int STORE_WINDOW = 4;
  // flash timing in microseconds, oscillator tick in ns
  localparam int WRITE_MIN_US = 3700;
  localparam int WRITE_MAX_US = 4500;
  localparam int TICK_NS = 1000;
  localparam int WRITE_TICKS = (WRITE_MIN_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int CLK_NS = 5;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  // core address register
  localparam logic [1:0] ADR_CMD = 2'h0;
  localparam logic [1:0] ADR_PTR = 2'h1;
  localparam logic [1:0] ADR_DATA = 2'h2;
  localparam logic [1:0] ADR_STAT = 2'h3;
endpackage

// *** test/flash_sp_monitor.sv ***
// Purpose: assertions on the self-programming link
// Assumes: one clock, reset active high
// Notes: sees interface signals only
`timescale 1ns/1ps
module flash_sp_monitor
  import flash_sp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // link
  input wire logic [7:0] ctrlWrData,
  input wire logic ctrlWr,
  input wire logic store,
  input wire logic eepromWriteBusy,
  input wire logic [7:0] ctrlStatus,
  input wire logic [12:0] fetchAddr,
  input wire logic fetchReq,
  input wire logic fetchOk
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // command accepted by the device
  wire take = ctrlWr && ctrlWrData[0] && !ctrlStatus[0] && !eepromWriteBusy;
  AST_TAKE: assert property (take |=> ctrlStatus[0])
    else $error("enable not set after command");
  AST_EE: assert property (ctrlWr && eepromWriteBusy && !ctrlStatus[0]
    |=> !ctrlStatus[0])
    else $error("command taken during eeprom write");
  AST_STORE: assert property (take && !ctrlWrData[4] |-> ##[1:4] store)
    else $error("no store after command");
  AST_HOLD: assert property ($rose(ctrlStatus[0]) && ctrlStatus[3:1] != 0
    |-> ctrlStatus[0] [*6] ##[1:20] !ctrlStatus[0])
    else $error("timed operation length wrong");
  AST_LOAD: assert property ($rose(ctrlStatus[0]) && ctrlStatus[4:1] == 0
    |-> ##[1:6] !ctrlStatus[0])
    else $error("load did not finish");
  AST_BUSY: assert property (ctrlStatus[6] && !(take && ctrlWrData[4])
    |=> ctrlStatus[6])
    else $error("section busy cleared without re-enable");
  AST_BLOCK: assert property (fetchReq && ctrlStatus[6]
    && fetchAddr < NON_CONC_START |-> !fetchOk)
    else $error("concurrent section readable while busy");
  AST_NON_CONCURRENT_SECTION: assert property (fetchReq && fetchAddr >= NON_CONC_START
    |-> fetchOk)
    else $error("non-concurrent section not readable");
endmodule // flash_sp_monitor

// *** test/test_flash_self_program_boot_partition.sv ***
// Purpose: self-checking bench of both self-programming ends
// Assumes: short flash timing parameters
// Notes: random data from xorshift seeded at 86
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_flash_self_program_boot_partition;
  import flash_sp_pkg::*;
  logic sys_clk = 0, reset = 1, wrStrobe = 0, rdStrobe = 0;
  logic eepromWriteBusy = 0, fetchReq = 0, cmdPending, hi = 0, lo = 0;
  logic [1:0] addr = 0;
  logic [15:0] wrData = 0, rdData, readData;
  logic [12:0] fetchAddr = 0, readAddr = 0, bootStart;
  logic [10:0] bootWords;
  logic [7:0] lockBits, lockExp;
  logic [23:0] bootExp;
  logic [31:0] rng = 32'h56;
  logic [15:0] buffer [4];
  logic [6:0] page;
  int fails = 0, n_tests = 0;
  flash_sp_if link();
  flash_sp_core core_inst (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .cmdPending(cmdPending),
    .eepromWriteBusy(eepromWriteBusy), .fetchAddr(fetchAddr),
    .fetchReq(fetchReq), .bus(link.core));
  flash_sp_ctrl #(.WRITE_TIME_TICKS(4), .TICK_DIV(2)) ctrl_inst (
    .sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .bootSizeSelHi(hi),
    .bootSizeSelLo(lo), .bus(link.device), .readAddr(readAddr),
    .readData(readData), .bootStart(bootStart), .bootWords(bootWords),
    .lockBits(lockBits));
  flash_sp_monitor flash_sp_monitor_inst (.sys_clk(sys_clk), .reset(reset),
    .ctrlWrData(link.ctrlWrData), .ctrlWr(link.ctrlWr), .store(link.store),
    .eepromWriteBusy(link.eepromWriteBusy), .ctrlStatus(link.ctrlStatus),
    .fetchAddr(link.fetchAddr), .fetchReq(link.fetchReq),
    .fetchOk(link.fetchOk));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [23:0] boot_exp(logic [1:0] s);
    case (s)
      2'h3: return {13'h1F80, 11'h080};
      2'h2: return {13'h1F00, 11'h100};
      2'h1: return {13'h1E00, 11'h200};
      default: return {13'h1C00, 11'h400};
    endcase
  endfunction
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
  endtask
  // wait for the enable bit to rise and clear again
  task automatic done();
    int t;
    for (t = 0; t < 20 && link.ctrlStatus[0] !== 1'b1; t++)
      @(posedge sys_clk);
    for (t = 0; t < 200 && (link.ctrlStatus[0] !== 1'b0
        || cmdPending !== 1'b0); t++)
      @(posedge sys_clk);
    if (t == 200) begin
      fails++;
      results();
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(ADR_CMD, {8'h00, c});
    done();
  endtask
  task automatic fetch(input logic [12:0] a, input logic ok);
    @(posedge sys_clk);
    fetchAddr <= a;
    fetchReq <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("fetchOk", ok, link.fetchOk)
    fetchReq <= 1'b0;
  endtask
  task automatic rd_flash(input logic [12:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    readAddr <= a;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("readData", e, readData)
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    `CHK("lockBits", 8'hFF, lockBits)
    for (int s = 0; s < 4; s++) begin
      {hi, lo} <= s[1:0];
      bootExp = boot_exp(s[1:0]);
      @(posedge sys_clk);
      #1 `CHK("bootStart", bootExp[23:11], bootStart)
      `CHK("bootWords", bootExp[10:0], bootWords)
    end
    rng = xs(rng);
    page = rng[6:0] % 7'd112;
    wr(ADR_PTR, {2'h3, page, 7'h00});
    cmd(CMD_ERASE);
    `CHK("sectionBusy", 1'b1, link.ctrlStatus[6])
    fetch({page, 6'h00}, 1'b0);
    fetch(13'h1C00 | rng[19:10], 1'b1);
    cmd(CMD_REEN);
    `CHK("sectionBusy", 1'b0, link.ctrlStatus[6])
    fetch({page, 6'h00}, 1'b1);
    rd_flash({page, 6'h05}, 16'hFFFF);
    for (int w = 0; w < 4; w++) begin
      rng = xs(rng);
      buffer[w] = rng[15:0];
      wr(ADR_DATA, buffer[w]);
      wr(ADR_PTR, {2'h2, page, 6'(w * 21), 1'b0});
      cmd(CMD_LOAD);
    end
    wr(ADR_PTR, {2'h1, page, 7'h00});
    @(posedge sys_clk);
    addr <= ADR_PTR;
    rdStrobe <= 1'b1;
    @(posedge sys_clk);
    rdStrobe <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK("pointer", {2'h1, page, 7'h00}, rdData)
    eepromWriteBusy <= 1'b1;
    wr(ADR_CMD, {8'h00, CMD_WRITE});
    repeat (10) @(posedge sys_clk);
    `CHK("enable", 1'b0, link.ctrlStatus[0])
    eepromWriteBusy <= 1'b0;
    done();
    cmd(CMD_REEN);
    for (int w = 0; w < 4; w++)
      rd_flash({page, 6'(w * 21)}, buffer[w]);
    rng = xs(rng);
    lockExp = (rng[7:0] & 8'h3C) | 8'hC3;
    wr(ADR_DATA, {8'h00, rng[7:0] & 8'h3C});
    cmd(CMD_LOCK);
    `CHK("lockBits", lockExp, lockBits)
    results();
  end
endmodule // test_flash_self_program_boot_partition
